//--- core/mscr_consts.vh
// constants for the motor start-up configuration register block
`ifndef MSCR_CONSTS_VH
`define MSCR_CONSTS_VH
`define MSCR_ADDR_CFG1        12'h084
`define MSCR_ADDR_OLCAP       12'h088
`define MSCR_ADDR_GENCAP      12'h08c
`define MSCR_ADDR_STATUS      12'h090
`define MSCR_CFG1_RESET       32'h00000000
`define MSCR_PARITY_BIT       31
`define MSCR_METHOD_HI        30
`define MSCR_METHOD_LO        29
`define MSCR_RAMP_HI          28
`define MSCR_RAMP_LO          25
`define MSCR_ALIGN_HI         24
`define MSCR_ALIGN_LO         21
`define MSCR_SCAP_HI          20
`define MSCR_SCAP_LO          17
`define MSCR_PRATE_HI         16
`define MSCR_PRATE_LO         14
`define MSCR_PTHR_HI          13
`define MSCR_PTHR_LO          9
`define MSCR_PREL_BIT         8
`define MSCR_PADV_HI          7
`define MSCR_PADV_LO          6
`define MSCR_PCNT_HI          5
`define MSCR_PCNT_LO          4
`define MSCR_OLSRC_BIT        3
`define MSCR_IQRAMP_BIT       2
`define MSCR_BRAKE_BIT        1
`define MSCR_REVSEL_BIT       0
`define MSCR_METHOD_ALIGN     2'h0
`define MSCR_METHOD_DALIGN    2'h1
`define MSCR_METHOD_IPD       2'h2
`define MSCR_METHOD_SLOW      2'h3
`define MSCR_RAMP_NOLIMIT     4'hf
`define MSCR_PTHR_MAXCODE     5'h11
`endif

//--- core/mscr_regs.v
// apb register bank for the motor start-up configuration
//
// What this block does
// - bits 30-29 pick the start-up method: align, double align, position detect or slow first cycle.
// - bits 28-25 code the start-up and open-loop current ramp rate, code f meaning no limit.
// - bits 24-21 code the align hold time from 10 ms to 10 s.
// - bits 20-17 code the align or slow first cycle current cap from 0.125 a to 8 a.
// - bits 16-14 code the position detect pulse rate from 50 hz to 10000 hz.
// - bits 13-9 code the position detect threshold, codes 12h to 1fh being not applicable.
// - bit 8 selects braking when clear and tristate when set after each detect pulse.
// - bits 7-6 code the advance angle of 0, 30, 60 or 90 degrees.
// - bits 5-4 code one detect run or an average of two, three or four runs.
// - bit 3 takes the open-loop cap from its own field when clear and from the general cap when set.
// - bit 2 enables the torque current ramp-down before closing the loop.
// - bit 1 enables active braking.
// - bit 0 selects forward or reverse drive open-loop settings during reverse drive.
// - the register lives at 84h and reads zero after reset.
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "mscr_consts.vh"

module mscr_regs (
  // apb clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  // motor control settings
  output wire [1:0]  startup_method,
  output wire        method_align,
  output wire        method_double_align,
  output wire        method_initial_position_detect,
  output wire        method_slow_first_cycle,
  output wire [3:0]  startup_ramp_rate,
  output wire        startup_ramp_unlimited,
  output wire [3:0]  align_hold_time,
  output wire [3:0]  startup_current_cap,
  output wire [2:0]  position_pulse_rate,
  output wire [4:0]  position_pulse_threshold,
  output wire        position_threshold_invalid,
  output wire        position_pulse_release,
  output wire [1:0]  position_advance_angle,
  output wire [2:0]  position_detect_runs,
  output wire        openloop_limit_source,
  output wire [3:0]  openloop_current_limit,
  output wire        torque_current_rampdown_on,
  output wire        active_brake_on,
  output wire        reverse_profile_select,
  output wire        config_parity
);

  // bus timing in short:
  // writes finish in the first access cycle, pready high at once
  // reads spend one wait state in which the selected word is loaded
  // into prdata, and complete in the next cycle with pready high
  // this keeps prdata a flip-flop while the master takes read data
  // at the very edge where it samples pready high
  // unmapped addresses complete normally but raise pslverr
  // nothing here depends on the setup cycle beyond address decode

  // read handshake states, one-hot
  localparam [1:0] RD_IDLE    = 2'b01;  // no read word loaded yet
  localparam [1:0] RD_DONE    = 2'b10;  // read word stands on prdata

  // address selects, one-hot in the order cfg1, olcap, gencap, status
  localparam [3:0] SEL_CFG1   = 4'b0001;
  localparam [3:0] SEL_OLCAP  = 4'b0010;
  localparam [3:0] SEL_GENCAP = 4'b0100;
  localparam [3:0] SEL_STATUS = 4'b1000;

  // configuration storage and next values
  reg  [31:0] cfg1_reg;
  reg  [31:0] cfg1_next;
  reg  [3:0]  olcap_reg;
  reg  [3:0]  olcap_next;
  reg  [3:0]  gencap_reg;
  reg  [3:0]  gencap_next;

  // read path
  reg  [1:0]  rd_state_reg;
  reg  [1:0]  rd_state_next;
  reg  [31:0] rd_word;
  wire [31:0] status_word;
  wire        rd_load;

  // bus qualifiers
  wire        access;
  wire        wr_en;
  wire        rd_access;
  wire        hit_cfg1;
  wire        hit_olcap;
  wire        hit_gencap;
  wire        hit_status;
  wire        hit_any;
  wire [3:0]  hit_vec;
  wire        wr_cfg1;
  wire        wr_olcap;
  wire        wr_gencap;

  // access phase of any transfer
  assign access     = psel & penable;

  // address decode over the full 12-bit byte address
  // only exact word addresses hit, so aliases answer as unmapped
  assign hit_cfg1   = (paddr == `MSCR_ADDR_CFG1);
  assign hit_olcap  = (paddr == `MSCR_ADDR_OLCAP);
  assign hit_gencap = (paddr == `MSCR_ADDR_GENCAP);
  assign hit_status = (paddr == `MSCR_ADDR_STATUS);
  assign hit_any    = hit_cfg1 | hit_olcap | hit_gencap | hit_status;
  assign hit_vec    = {hit_status, hit_gencap, hit_olcap, hit_cfg1};

  // write strobes, no wait states on writes
  // the status word has no strobe, so writes to it are dropped quietly
  assign wr_en      = access & pwrite & hit_any;
  assign wr_cfg1    = wr_en & hit_cfg1;
  assign wr_olcap   = wr_en & hit_olcap;
  assign wr_gencap  = wr_en & hit_gencap;

  // read qualifiers, load happens in the wait state only
  assign rd_access  = access & ~pwrite;
  assign rd_load    = rd_access & (rd_state_reg == RD_IDLE);

  // ready low only in the first access cycle of a read
  assign pready     = ~rd_access | (rd_state_reg == RD_DONE);

  // error shown on the completing cycle of an unmapped access
  assign pslverr    = access & pready & ~hit_any;

  // config word next value, parity carried as written
  // the parity bit is stored and never checked here
  always @* begin
    cfg1_next = cfg1_reg;
    if (wr_cfg1) begin
      cfg1_next = pwdata;
    end
  end

  // open-loop cap next value, low nibble only
  always @* begin
    olcap_next = olcap_reg;
    if (wr_olcap) begin
      olcap_next = pwdata[3:0];
    end
  end

  // general cap next value, low nibble only
  always @* begin
    gencap_next = gencap_reg;
    if (wr_gencap) begin
      gencap_next = pwdata[3:0];
    end
  end

  // register storage, all zero after reset
  // settings derived below follow the stored word with no extra delay
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg1_reg   <= `MSCR_CFG1_RESET;
      olcap_reg  <= 4'h0;
      gencap_reg <= 4'h0;
    end else begin
      cfg1_reg   <= cfg1_next;
      olcap_reg  <= olcap_next;
      gencap_reg <= gencap_next;
    end
  end

  // read-only status word
  // [1:0] method, [5:2] effective open-loop cap, [6] no ramp limit,
  // [7] threshold code out of range
  assign status_word = {24'h000000, position_threshold_invalid, startup_ramp_unlimited,
                        openloop_current_limit, startup_method};

  // read word select
  always @* begin
    rd_word = 32'h00000000;
    case (hit_vec)
      SEL_CFG1: begin
        rd_word = cfg1_reg;
      end
      SEL_OLCAP: begin
        rd_word = {28'h0000000, olcap_reg};
      end
      SEL_GENCAP: begin
        rd_word = {28'h0000000, gencap_reg};
      end
      SEL_STATUS: begin
        rd_word = status_word;
      end
      default: begin
        rd_word = 32'h00000000;                      // unmapped reads give zero
      end
    endcase
  end

  // read handshake next state
  // one wait state per read, back to idle once the read completes
  always @* begin
    rd_state_next = rd_state_reg;
    case (rd_state_reg)
      RD_IDLE: begin
        if (rd_access) begin
          rd_state_next = RD_DONE;
        end
      end
      RD_DONE: begin
        rd_state_next = RD_IDLE;                     // read completes here
      end
      default: begin
        rd_state_next = RD_IDLE;
      end
    endcase
  end

  // read handshake state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_state_reg <= RD_IDLE;
    end else begin
      rd_state_reg <= rd_state_next;
    end
  end

  // read data register, loaded at the end of the wait state
  // holds its value until the next read is loaded
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_load) begin
      prdata <= rd_word;
    end
  end

  // start-up method code and its one-hot decode
  // exactly one method line is high at any time
  assign startup_method                 = cfg1_reg[`MSCR_METHOD_HI:`MSCR_METHOD_LO];
  assign method_align                   = (startup_method == `MSCR_METHOD_ALIGN);
  assign method_double_align            = (startup_method == `MSCR_METHOD_DALIGN);
  assign method_initial_position_detect = (startup_method == `MSCR_METHOD_IPD);
  assign method_slow_first_cycle        = (startup_method == `MSCR_METHOD_SLOW);

  // current ramp rate code for align, slow cycle and open loop
  // the top code lifts the limit, flagged for the ramp generator
  assign startup_ramp_rate              = cfg1_reg[`MSCR_RAMP_HI:`MSCR_RAMP_LO];
  assign startup_ramp_unlimited         = (startup_ramp_rate == `MSCR_RAMP_NOLIMIT);

  // align hold time code, scaled by the sequencer
  assign align_hold_time                = cfg1_reg[`MSCR_ALIGN_HI:`MSCR_ALIGN_LO];

  // align or slow first cycle current cap code
  assign startup_current_cap            = cfg1_reg[`MSCR_SCAP_HI:`MSCR_SCAP_LO];

  // position detect pulse rate code
  assign position_pulse_rate            = cfg1_reg[`MSCR_PRATE_HI:`MSCR_PRATE_LO];

  // position detect threshold code
  // codes above the top valid code are kept as written but flagged,
  // so the detector can refuse to run on a meaningless threshold
  assign position_pulse_threshold       = cfg1_reg[`MSCR_PTHR_HI:`MSCR_PTHR_LO];
  assign position_threshold_invalid     = (position_pulse_threshold > `MSCR_PTHR_MAXCODE);

  // release after each pulse: low brakes, high tristates
  assign position_pulse_release         = cfg1_reg[`MSCR_PREL_BIT];

  // advance angle code added to the detected position
  assign position_advance_angle         = cfg1_reg[`MSCR_PADV_HI:`MSCR_PADV_LO];

  // number of detect runs to average, one to four
  // widened by a bit so the top count does not wrap
  assign position_detect_runs           = {1'b0, cfg1_reg[`MSCR_PCNT_HI:`MSCR_PCNT_LO]} + 3'h1;

  // open-loop cap source and the cap actually in force
  // low takes the dedicated cap, high the general cap
  assign openloop_limit_source          = cfg1_reg[`MSCR_OLSRC_BIT];
  assign openloop_current_limit         = openloop_limit_source ? gencap_reg : olcap_reg;

  // torque current ramp-down before closing the loop
  assign torque_current_rampdown_on     = cfg1_reg[`MSCR_IQRAMP_BIT];

  // active braking enable
  assign active_brake_on                = cfg1_reg[`MSCR_BRAKE_BIT];

  // reverse drive profile: low forward settings, high reverse settings
  assign reverse_profile_select         = cfg1_reg[`MSCR_REVSEL_BIT];

  // stored parity bit, passed on unchecked
  assign config_parity                  = cfg1_reg[`MSCR_PARITY_BIT];

endmodule // mscr_regs

//--- verif/mscr_checker.sv
// assertion checker for the start-up config register bank
`timescale 1ns/1ps
module mscr_checker (
  input wire        pclk, presetn, psel, penable, pwrite, pslverr,
  input wire        config_parity, method_slow_first_cycle, position_threshold_invalid,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [1:0]  startup_method,
  input wire [3:0]  align_hold_time, startup_current_cap,
  input wire [4:0]  position_pulse_threshold,
  input wire [2:0]  position_detect_runs
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // write access to the config word, then field relations
  sequence s_wr; psel && penable && pwrite && paddr == 12'h084; endsequence
  property p_meth; s_wr |=> startup_method == $past(pwdata[30:29]); endproperty
  property p_slow; method_slow_first_cycle == (startup_method == 2'h3); endproperty
  property p_time; s_wr |=> align_hold_time == $past(pwdata[24:21]); endproperty
  property p_cap; s_wr |=> startup_current_cap == $past(pwdata[20:17]); endproperty
  property p_runs; s_wr |=> position_detect_runs == {1'h0, $past(pwdata[5:4])} + 3'h1; endproperty
  property p_par; s_wr |=> config_parity == $past(pwdata[31]); endproperty
  property p_thr; position_threshold_invalid == (position_pulse_threshold > 5'h11); endproperty
  property p_err; psel && penable && paddr == 12'h084 |-> !pslverr; endproperty
  a_meth: assert property (p_meth) else $error("method lost");
  a_slow: assert property (p_slow) else $error("slow decode");
  a_time: assert property (p_time) else $error("align time lost");
  a_cap: assert property (p_cap) else $error("current cap lost");
  a_runs: assert property (p_runs) else $error("run count");
  a_par: assert property (p_par) else $error("parity lost");
  a_thr: assert property (p_thr) else $error("threshold flag");
  a_err: assert property (p_err) else $error("mapped error");
endmodule // mscr_checker
bind mscr_regs mscr_checker chk_u (.*);

//--- verif/mscr_regs_tb.sv
// self-checking bench for the start-up config register bank
`timescale 1ns/1ps
module mscr_regs_tb;
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, rd;
  logic [31:0] v [2] = '{{3'h5, 4'hf, 4'ha, 4'h5, 3'h6, 5'h12, 3'h7, 2'h3, 4'h5},
                         {3'h2, 4'he, 4'h0, 4'hf, 3'h0, 5'h11, 3'h0, 2'h0, 4'ha}};
  wire  [31:0] prdata;
  wire  [1:0]  startup_method, position_advance_angle;
  wire  [3:0]  startup_ramp_rate, align_hold_time, startup_current_cap, openloop_current_limit;
  wire  [2:0]  position_pulse_rate, position_detect_runs;
  wire  [4:0]  position_pulse_threshold;
  wire         pready, pslverr, method_align, method_double_align, method_initial_position_detect;
  wire         method_slow_first_cycle, startup_ramp_unlimited, position_threshold_invalid, config_parity;
  wire         position_pulse_release, openloop_limit_source, torque_current_rampdown_on, active_brake_on;
  wire         reverse_profile_select;
  int          n_fail = 0, check_count = 0;
  mscr_regs dut_u (.*);
  initial forever #4 pclk = ~pclk;
  // verdict and end of run
  task conclude;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer; response and read data taken at the edge where pready is high
  task xfer(input w, input [11:0] a, input [31:0] d);
    int i;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'h1;
    i = 0;
    do @(posedge pclk); while (pready !== 1'h1 && ++i < 16);
    if (i == 16) begin n_fail++; conclude; end
    err = pslverr;
    rd = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  // reset, method codes, field walk, cap source, refusal, second reset
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    xfer(1'h0, 12'h084, 32'h0);
    chk(rd, 32'h0);
    chk({method_align, position_detect_runs}, {1'h1, 3'h1});
    for (int m = 0; m < 4; m++) begin
      xfer(1'h1, 12'h084, {1'h0, m[1:0], 29'h0});
      chk({method_slow_first_cycle, method_initial_position_detect, method_double_align, method_align}, 32'h1 << m);
    end
    $display("test reset and methods done");
    foreach (v[k]) begin
      xfer(1'h1, 12'h084, v[k]);
      xfer(1'h0, 12'h084, 32'h0);
      chk(rd, v[k]);
      chk({startup_ramp_unlimited, startup_ramp_rate}, {&v[k][28:25], v[k][28:25]});
      chk({align_hold_time, startup_current_cap, position_pulse_rate}, v[k][24:14]);
      chk({position_threshold_invalid, position_pulse_threshold}, {v[k][13:9] > 5'h11, v[k][13:9]});
      chk({position_pulse_release, position_advance_angle}, v[k][8:6]);
      chk(position_detect_runs, v[k][5:4] + 3'h1);
      chk({openloop_limit_source, torque_current_rampdown_on, active_brake_on, reverse_profile_select}, v[k][3:0]);
      chk({config_parity, startup_method}, v[k][31:29]);
    end
    xfer(1'h1, 12'h088, 32'h3);
    xfer(1'h1, 12'h08c, 32'hc);
    for (int s = 0; s < 2; s++) begin
      xfer(1'h1, 12'h084, {28'h0, s[0], 3'h0});
      chk(openloop_current_limit, s ? 32'hc : 32'h3);
    end
    xfer(1'h0, 12'h090, 32'h0);
    chk(rd, 32'h30);
    chk(err, 1'h0);
    $display("test fields done");
    xfer(1'h1, 12'h0fc, 32'hffffffff);
    chk(err, 1'h1);
    xfer(1'h0, 12'h084, 32'h0);
    chk(err, 1'h0);
    chk(rd, 32'h8);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    xfer(1'h0, 12'h084, 32'h0);
    chk(rd, 32'h0);
    $display("test refusal and reset done");
    conclude;
  end
endmodule // mscr_regs_tb
